// file: hdl/aolc_pkg.sv
/*
 Package for the ADC output and link control register bank: register offsets,
 field positions, reset values and derived counts.
 Assumes a single 250 MHz clock domain and an 8-bit register port.
// Summary of operation
// RULE1: Reorder bit three applies channel reorder map
// RULE2: Software sets companion bit seven with reorder
// RULE3: LSB select honoured only when enabled
// RULE4: Code 11 puts over-range flag in LSB
// RULE5: Codes 01 and 10 keep full data
// RULE6: Digital reset bit pulses, then self-clears
// RULE7: Multiframe enable picks five or register count
// RULE8: Bit four sends long transport pattern
// RULE9: Bit three reverses output bit order
// RULE10: Bit two inserts lane alignment characters
// RULE11: Bit one inserts frame alignment characters
// RULE12: Bit zero skips initial lane alignment
// RULE13: Software writes zero to reserved bits
// RULE14: Sync from pin or register; register forces K28.5
*/
package aolc_pkg;
    localparam int          AOLC_AW             = 8;
    localparam int          AOLC_DW             = 8;
    localparam int          AOLC_SW             = 16;
    localparam logic [7:0]  AOLC_OFS_LINK_CTRL  = 8'h00;
    localparam logic [7:0]  AOLC_OFS_SYNC_CTRL  = 8'h01;
    localparam logic [7:0]  AOLC_OFS_K_COUNT    = 8'h06;
    localparam logic [7:0]  AOLC_OFS_REORD_MAP  = 8'h70;
    localparam logic [7:0]  AOLC_OFS_REORD_EN   = 8'h72;
    localparam logic [7:0]  AOLC_OFS_LSB_EN     = 8'hAB;
    localparam logic [7:0]  AOLC_OFS_LSB_SEL    = 8'hAD;
    localparam logic [7:0]  AOLC_OFS_IRQ_STAT   = 8'hE0;
    localparam logic [7:0]  AOLC_OFS_IRQ_MASK   = 8'hE1;
    localparam logic [7:0]  AOLC_OFS_DIG_RST    = 8'hF7;
    localparam int          AOLC_B_CTRL_K       = 7;
    localparam int          AOLC_B_TESTMODE     = 4;
    localparam int          AOLC_B_FLIP         = 3;
    localparam int          AOLC_B_LANE_ALIGN   = 2;
    localparam int          AOLC_B_FRAME_ALIGN  = 1;
    localparam int          AOLC_B_ILA_DIS      = 0;
    localparam int          AOLC_B_REORD_EN     = 3;
    localparam int          AOLC_B_LSB_EN       = 0;
    localparam int          AOLC_B_DIG_RST      = 0;
    localparam int          AOLC_B_SYNC_REG     = 7;
    localparam int          AOLC_B_SYNC_REG_EN  = 6;
    localparam logic [7:0]  AOLC_LINK_WMASK     = 8'h9F;
    localparam logic [7:0]  AOLC_SYNC_WMASK     = 8'hC0;
    localparam logic [1:0]  AOLC_LSB_FAST_OVERRANGE_FLAG       = 2'h3;
    localparam logic [4:0]  AOLC_K_DEFAULT      = 5'h05;
    localparam logic [7:0]  AOLC_RST_ZERO       = 8'h00;
    localparam logic [7:0]  AOLC_K28_5          = 8'hBC;
    localparam logic [7:0]  AOLC_K28_3          = 8'h7C;
    localparam logic [7:0]  AOLC_K28_7          = 8'hFC;
    localparam int          AOLC_CLK_MHZ        = 250;
    localparam int          AOLC_RST_PULSE_NS   = 16;
    localparam int          AOLC_RST_PULSE_CYC  = (AOLC_RST_PULSE_NS * AOLC_CLK_MHZ + 999) / 1000;
    localparam int          AOLC_IRQ_W          = 3;
    localparam int          AOLC_IRQ_SYNC       = 0;
    localparam int          AOLC_IRQ_FAST_OVERRANGE_FLAG       = 1;
    localparam int          AOLC_IRQ_DRST       = 2;
    typedef enum logic [1:0] {
        AOLC_RUN   = 2'b00,
        AOLC_PULSE = 2'b01,
        AOLC_DONE  = 2'b11
    } aolc_rst_state_t;
endpackage

// file: hdl/aolc_lane_shaper.sv
/*
 Per-channel sample shaper: over-range LSB replacement, bit reversal and
 reordering by a per-bit map. Registered output.
 Assumes samples arrive on clk with no back-pressure.
*/
`timescale 1ns/1ps
`default_nettype none
module aolc_lane_shaper
    import aolc_pkg::*;
#(
    parameter int SW = AOLC_SW
) (
    input  wire logic          clk,
    input  wire logic          nrst,
    input  wire logic [SW-1:0] sample,
    input  wire logic          fast_overrange_flag,
    input  wire logic          lsb_fast_overrange_flag,
    input  wire logic          flip,
    input  wire logic          reorder_en,
    input  wire logic [7:0]    channel_reorder_map,
    output logic      [SW-1:0] shaped
);
    logic [SW-1:0] with_flag;
    logic [SW-1:0] flipped;
    logic [SW-1:0] reordered;

    // LSB carries the over-range flag only for code 11
    assign with_flag = lsb_fast_overrange_flag ? {sample[SW-1:1], fast_overrange_flag} : sample; // RULE4 RULE5

    genvar i;
    generate
        for (i = 0; i < SW; i++) begin : g_bit
            assign flipped[i] = flip ? with_flag[SW-1-i] : with_flag[i]; // RULE9
            // Map bit picks swapping of each adjacent byte-pair position
            assign reordered[i] = (reorder_en && channel_reorder_map[i % 8])
                                  ? flipped[i ^ 8] : flipped[i]; // RULE1
        end
    endgenerate

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            shaped <= '0;
        end else begin
            shaped <= reordered;
        end
    end
endmodule
`default_nettype wire

// file: hdl/aolc_top.sv
/*
 ADC output and link control register bank with its data path controls:
 two channel shapers, link character insertion, sync source selection,
 self-clearing digital reset and a masked interrupt.
 Assumes a plain register port on clk; synchronisers sit on asynchronous
 pins only for sync, samples come from the same clock.
*/
// The strobed register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module aolc_top
    import aolc_pkg::*;
#(
    parameter int SW = AOLC_SW
) (
    input  wire logic               clk,
    input  wire logic               nrst,
    input  wire logic [AOLC_AW-1:0] reg_addr,
    input  wire logic [AOLC_DW-1:0] reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic      [AOLC_DW-1:0] reg_rdata,
    input  wire logic [SW-1:0]      sample_a,
    input  wire logic [SW-1:0]      sample_b,
    input  wire logic               fast_overrange_flag_a,
    input  wire logic               fast_overrange_flag_b,
    input  wire logic               sync_n_pin,
    output logic      [SW-1:0]      data_a,
    output logic      [SW-1:0]      data_b,
    output logic                    data_is_k,
    output logic                    data_is_pattern,
    output logic                    lane_align_en,
    output logic                    frame_align_en,
    output logic                    ila_skip,
    output logic                    sync_req,
    output logic      [4:0]         frames_per_multiframe,
    output logic                    digital_block_reset_bit,
    output logic                    irq
);
    logic [7:0]      link_transmit_control;
    logic [7:0]      sync_control;
    logic [4:0]      k_count;
    logic [7:0]      channel_reorder_map;
    logic            reorder_en;
    logic            lsb_en;
    logic [1:0]      lsb_select;
    logic [AOLC_IRQ_W-1:0] irq_stat;
    logic [AOLC_IRQ_W-1:0] irq_mask;
    logic [AOLC_IRQ_W-1:0] irq_evt;
    logic            sync_m;
    logic            sync_s;
    logic            sync_s_d;
    logic            sync_req_now;
    logic            lsb_fast_overrange_flag;
    logic [SW-1:0]   shaped_a;
    logic [SW-1:0]   shaped_b;
    logic [3:0]      rst_cnt;
    logic            rst_go;
    logic            wr_hit_rst;
    aolc_rst_state_t rst_state;
    aolc_rst_state_t next_rst_state;

    assign wr_hit_rst = reg_wr && reg_addr == AOLC_OFS_DIG_RST && reg_wdata[AOLC_B_DIG_RST];

    // Register writes; reserved bits are forced to zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            link_transmit_control <= AOLC_RST_ZERO;
            sync_control          <= AOLC_RST_ZERO;
            k_count               <= AOLC_K_DEFAULT;
            channel_reorder_map   <= AOLC_RST_ZERO;
            reorder_en            <= 1'b0;
            lsb_en                <= 1'b0;
            lsb_select            <= 2'h0;
            irq_mask              <= '0;
        end else if (reg_wr) begin
            case (reg_addr)
                AOLC_OFS_LINK_CTRL: link_transmit_control <= reg_wdata & AOLC_LINK_WMASK;
                AOLC_OFS_SYNC_CTRL: sync_control <= reg_wdata & AOLC_SYNC_WMASK;
                AOLC_OFS_K_COUNT:   k_count <= reg_wdata[4:0];
                AOLC_OFS_REORD_MAP: channel_reorder_map <= reg_wdata;
                AOLC_OFS_REORD_EN:  reorder_en <= reg_wdata[AOLC_B_REORD_EN]; // RULE1 RULE2
                AOLC_OFS_LSB_EN:    lsb_en <= reg_wdata[AOLC_B_LSB_EN];
                AOLC_OFS_LSB_SEL:   lsb_select <= reg_wdata[1:0];
                AOLC_OFS_IRQ_MASK:  irq_mask <= reg_wdata[AOLC_IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // Read data one cycle after the strobe; write-only registers read zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                AOLC_OFS_LINK_CTRL: reg_rdata <= link_transmit_control;
                AOLC_OFS_SYNC_CTRL: reg_rdata <= sync_control;
                AOLC_OFS_K_COUNT:   reg_rdata <= {3'h0, k_count};
                AOLC_OFS_LSB_EN:    reg_rdata <= {7'h00, lsb_en};
                AOLC_OFS_LSB_SEL:   reg_rdata <= {6'h00, lsb_select};
                AOLC_OFS_IRQ_STAT:  reg_rdata <= {5'h00, irq_stat};
                AOLC_OFS_IRQ_MASK:  reg_rdata <= {5'h00, irq_mask};
                default:            reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    // Sync pin enters through two flops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync_m   <= 1'b1;
            sync_s   <= 1'b1;
            sync_s_d <= 1'b1;
        end else begin
            sync_m   <= sync_n_pin;
            sync_s   <= sync_m;
            sync_s_d <= sync_s;
        end
    end

    // Register source overrides the pin when enabled
    assign sync_req_now = sync_control[AOLC_B_SYNC_REG_EN] ? sync_control[AOLC_B_SYNC_REG] : !sync_s; // RULE14

    // Self-clearing digital reset pulse
    always_comb begin
        next_rst_state = rst_state;
        case (rst_state)
            AOLC_RUN:   if (wr_hit_rst) next_rst_state = AOLC_PULSE;
            AOLC_PULSE: if (rst_cnt == 4'(AOLC_RST_PULSE_CYC - 1)) next_rst_state = AOLC_DONE;
            AOLC_DONE:  next_rst_state = AOLC_RUN;
            default:    next_rst_state = AOLC_RUN;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_state <= AOLC_RUN;
            rst_cnt   <= '0;
        end else begin
            rst_state <= next_rst_state;
            rst_cnt   <= (rst_state == AOLC_PULSE) ? rst_cnt + 4'h1 : 4'h0;
        end
    end

    assign rst_go = (rst_state == AOLC_PULSE);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            digital_block_reset_bit <= 1'b0;
        end else begin
            digital_block_reset_bit <= rst_go; // RULE6
        end
    end

    // Interrupt events: sync request edge, over-range, reset done
    assign irq_evt[AOLC_IRQ_SYNC] = sync_s_d && !sync_s;
    assign irq_evt[AOLC_IRQ_FAST_OVERRANGE_FLAG] = fast_overrange_flag_a || fast_overrange_flag_b;
    assign irq_evt[AOLC_IRQ_DRST] = (rst_state == AOLC_DONE);

    // Set beats write-one-to-clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_stat <= '0;
        end else if (reg_wr && reg_addr == AOLC_OFS_IRQ_STAT) begin
            irq_stat <= (irq_stat & ~reg_wdata[AOLC_IRQ_W-1:0]) | irq_evt;
        end else begin
            irq_stat <= irq_stat | irq_evt;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat & irq_mask);
        end
    end

    assign lsb_fast_overrange_flag = lsb_en && (lsb_select == AOLC_LSB_FAST_OVERRANGE_FLAG); // RULE3

    aolc_lane_shaper #(.SW(SW)) u_shape_a (
        .clk                 (clk),
        .nrst                (nrst),
        .sample              (sample_a),
        .fast_overrange_flag (fast_overrange_flag_a),
        .lsb_fast_overrange_flag            (lsb_fast_overrange_flag),
        .flip                (link_transmit_control[AOLC_B_FLIP]),
        .reorder_en          (reorder_en),
        .channel_reorder_map (channel_reorder_map),
        .shaped              (shaped_a)
    );

    aolc_lane_shaper #(.SW(SW)) u_shape_b (
        .clk                 (clk),
        .nrst                (nrst),
        .sample              (sample_b),
        .fast_overrange_flag (fast_overrange_flag_b),
        .lsb_fast_overrange_flag            (lsb_fast_overrange_flag),
        .flip                (link_transmit_control[AOLC_B_FLIP]),
        .reorder_en          (reorder_en),
        .channel_reorder_map (channel_reorder_map),
        .shaped              (shaped_b)
    );

    // Output stage: K28.5 fill on register sync request, else shaped data
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            data_a    <= '0;
            data_b    <= '0;
            data_is_k <= 1'b0;
        end else if (sync_control[AOLC_B_SYNC_REG_EN] && sync_control[AOLC_B_SYNC_REG]) begin
            data_a    <= {AOLC_K28_5, AOLC_K28_5}; // RULE14
            data_b    <= {AOLC_K28_5, AOLC_K28_5};
            data_is_k <= 1'b1;
        end else begin
            data_a    <= shaped_a;
            data_b    <= shaped_b;
            data_is_k <= 1'b0;
        end
    end

    // Link framing controls to the transmitter
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            data_is_pattern       <= 1'b0;
            lane_align_en         <= 1'b0;
            frame_align_en        <= 1'b0;
            ila_skip              <= 1'b0;
            sync_req              <= 1'b0;
            frames_per_multiframe <= AOLC_K_DEFAULT;
        end else begin
            data_is_pattern       <= link_transmit_control[AOLC_B_TESTMODE]; // RULE8
            lane_align_en         <= link_transmit_control[AOLC_B_LANE_ALIGN]; // RULE10
            frame_align_en        <= link_transmit_control[AOLC_B_FRAME_ALIGN]; // RULE11
            ila_skip              <= link_transmit_control[AOLC_B_ILA_DIS]; // RULE12
            sync_req              <= sync_req_now;
            frames_per_multiframe <= link_transmit_control[AOLC_B_CTRL_K] ? k_count : AOLC_K_DEFAULT; // RULE7
        end
    end

    chk_reset_self_clears: assert property (@(posedge clk) disable iff (!nrst) // RULE6
        wr_hit_rst && rst_state == AOLC_RUN |-> ##2 digital_block_reset_bit ##4 !digital_block_reset_bit)
        else $error("digital reset pulse length wrong");

    chk_kcount_select: assert property (@(posedge clk) disable iff (!nrst) // RULE7
        !link_transmit_control[AOLC_B_CTRL_K] && $stable(link_transmit_control) |=> frames_per_multiframe == AOLC_K_DEFAULT)
        else $error("frames per multiframe not default");

    chk_pattern_follows: assert property (@(posedge clk) disable iff (!nrst) // RULE8
        data_is_pattern == $past(link_transmit_control[AOLC_B_TESTMODE]))
        else $error("pattern enable not following control");

    chk_lane_align: assert property (@(posedge clk) disable iff (!nrst) // RULE10
        $rose(link_transmit_control[AOLC_B_LANE_ALIGN]) |=> lane_align_en)
        else $error("lane alignment enable late");

    chk_frame_align: assert property (@(posedge clk) disable iff (!nrst) // RULE11
        $fell(link_transmit_control[AOLC_B_FRAME_ALIGN]) |=> !frame_align_en)
        else $error("frame alignment enable stuck");

    chk_ila_skip: assert property (@(posedge clk) disable iff (!nrst) // RULE12
        reg_wr && reg_addr == AOLC_OFS_LINK_CTRL |-> ##2 ila_skip == $past(reg_wdata[AOLC_B_ILA_DIS], 2))
        else $error("ila skip not from write");

    chk_k_fill: assert property (@(posedge clk) disable iff (!nrst) // RULE14
        sync_control[AOLC_B_SYNC_REG_EN] && sync_control[AOLC_B_SYNC_REG] |=> data_is_k && data_a[7:0] == AOLC_K28_5)
        else $error("K28.5 fill missing");

    chk_lsb_gate: assert property (@(posedge clk) disable iff (!nrst) // RULE3
        !lsb_en && !link_transmit_control[AOLC_B_FLIP] && !reorder_en
        |-> ##2 (data_is_k || data_a[0] == $past(sample_a[0], 2)))
        else $error("LSB replacement without enable");

    chk_fast_overrange_flag_lsb: assert property (@(posedge clk) disable iff (!nrst) // RULE4
        lsb_fast_overrange_flag && !link_transmit_control[AOLC_B_FLIP] && !reorder_en
        && !sync_control[AOLC_B_SYNC_REG_EN] && $stable(link_transmit_control)
        |-> ##2 data_a[0] == $past(fast_overrange_flag_a, 2))
        else $error("over-range flag not in LSB");

    chk_link_read: assert property (@(posedge clk) disable iff (!nrst) // RULE12
        reg_rd && reg_addr == AOLC_OFS_LINK_CTRL |=> reg_rdata == $past(link_transmit_control))
        else $error("link control readback wrong");

    chk_reorder_wo: assert property (@(posedge clk) disable iff (!nrst) // RULE1
        reg_rd && reg_addr == AOLC_OFS_REORD_EN |=> reg_rdata == AOLC_RST_ZERO)
        else $error("write-only reorder enable read back");

    chk_lsb_en_read: assert property (@(posedge clk) disable iff (!nrst) // RULE3
        reg_rd && reg_addr == AOLC_OFS_LSB_EN |=> reg_rdata == {7'h00, $past(lsb_en)})
        else $error("LSB enable readback wrong");

    chk_lsb_sel_read: assert property (@(posedge clk) disable iff (!nrst) // RULE4
        reg_rd && reg_addr == AOLC_OFS_LSB_SEL |=> reg_rdata == {6'h00, $past(lsb_select)})
        else $error("LSB select readback wrong");

    chk_kcount_read: assert property (@(posedge clk) disable iff (!nrst) // RULE7
        reg_rd && reg_addr == AOLC_OFS_K_COUNT |=> reg_rdata == {3'h0, $past(k_count)})
        else $error("frame count readback wrong");

    chk_kcount_reg: assert property (@(posedge clk) disable iff (!nrst) // RULE7
        link_transmit_control[AOLC_B_CTRL_K] |=> frames_per_multiframe == $past(k_count))
        else $error("frames per multiframe not from register");

    chk_reset_bound: assert property (@(posedge clk) disable iff (!nrst) // RULE6
        rst_state == AOLC_PULSE |-> rst_cnt < 4'(AOLC_RST_PULSE_CYC))
        else $error("digital reset pulse overruns");

    chk_lane_off: assert property (@(posedge clk) disable iff (!nrst) // RULE10
        $fell(link_transmit_control[AOLC_B_LANE_ALIGN]) |=> !lane_align_en)
        else $error("lane alignment enable stuck");

    chk_frame_on: assert property (@(posedge clk) disable iff (!nrst) // RULE11
        $rose(link_transmit_control[AOLC_B_FRAME_ALIGN]) |=> frame_align_en)
        else $error("frame alignment enable late");

    chk_sync_pin_src: assert property (@(posedge clk) disable iff (!nrst) // RULE14
        !sync_control[AOLC_B_SYNC_REG_EN] |=> sync_req == !$past(sync_s))
        else $error("sync request not from pin");

    chk_sync_reg_src: assert property (@(posedge clk) disable iff (!nrst) // RULE14
        sync_control[AOLC_B_SYNC_REG_EN] |=> sync_req == $past(sync_control[AOLC_B_SYNC_REG]))
        else $error("sync request not from register");

    chk_k_fill_b: assert property (@(posedge clk) disable iff (!nrst) // RULE14
        sync_control[AOLC_B_SYNC_REG_EN] && sync_control[AOLC_B_SYNC_REG] |=> data_b == {AOLC_K28_5, AOLC_K28_5})
        else $error("K28.5 fill missing on channel b");

    chk_flip_ends: assert property (@(posedge clk) disable iff (!nrst) // RULE9
        link_transmit_control[AOLC_B_FLIP] && !reorder_en && !lsb_fast_overrange_flag |-> ##2 (data_is_k
        || (data_a[0] == $past(sample_a[SW-1], 2) && data_a[SW-1] == $past(sample_a[0], 2))))
        else $error("bit order not reversed");

    chk_reorder_swap: assert property (@(posedge clk) disable iff (!nrst) // RULE1
        reorder_en && !link_transmit_control[AOLC_B_FLIP] && !lsb_fast_overrange_flag |-> ##2 (data_is_k
        || data_a[0] == ($past(channel_reorder_map[0], 2) ? $past(sample_a[SW/2], 2) : $past(sample_a[0], 2))))
        else $error("reorder map not applied");

    chk_fast_overrange_flag_lsb_b: assert property (@(posedge clk) disable iff (!nrst) // RULE4
        lsb_fast_overrange_flag && !link_transmit_control[AOLC_B_FLIP] && !reorder_en
        |-> ##2 (data_is_k || data_b[0] == $past(fast_overrange_flag_b, 2)))
        else $error("over-range flag not in LSB of channel b");

    chk_full_data: assert property (@(posedge clk) disable iff (!nrst) // RULE5
        !lsb_fast_overrange_flag && !link_transmit_control[AOLC_B_FLIP] && !reorder_en
        |-> ##2 (data_is_k || data_b == $past(sample_b, 2)))
        else $error("full data not passed");
endmodule
`default_nettype wire

// file: sim/aolc_rx_model.sv
/*
 Behavioural model of the link receiver on the far side of the block:
 it raises an active-low sync request on command of the bench.
 Assumes the same clk and nrst as the block under test.
*/
`timescale 1ns/1ps
`default_nettype none
module aolc_rx_model (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic want_sync,
    output logic      sync_n_pin
);
    // Request held low only while the receiver wants a resync; idle level is high
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync_n_pin <= 1'b1;
        end else begin
            sync_n_pin <= !want_sync;
        end
    end
endmodule
`default_nettype wire

// file: sim/testbench.sv
/*
 Self-checking bench for the output and link control register bank.
 Assumes aolc_pkg is compiled first and the receiver model is available.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import aolc_pkg::*;
    logic        clk, nrst, reg_wr, reg_rd, fast_overrange_flag_a, fast_overrange_flag_b, want_sync, sync_n_pin;
    logic        rd_seen = 1'b0;
    logic        data_is_k, data_is_pattern, lane_align_en, frame_align_en, ila_skip, sync_req, drst, irq;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, map;
    logic [15:0] sample_a, sample_b, data_a, data_b;
    logic [4:0]  fpm;
    logic [7:0]  exp_q[$];
    logic [31:0] rng = 32'h10;
    int          n_errors = 0;
    int          check_count = 0;
    int          cycles = 0;
    int          hi;

    aolc_top u_dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_a(sample_a), .sample_b(sample_b), .fast_overrange_flag_a(fast_overrange_flag_a),
        .fast_overrange_flag_b(fast_overrange_flag_b), .sync_n_pin(sync_n_pin), .data_a(data_a), .data_b(data_b), .data_is_k(data_is_k),
        .data_is_pattern(data_is_pattern), .lane_align_en(lane_align_en), .frame_align_en(frame_align_en),
        .ila_skip(ila_skip), .sync_req(sync_req), .frames_per_multiframe(fpm),
        .digital_block_reset_bit(drst), .irq(irq));
    aolc_rx_model u_rx (.clk(clk), .nrst(nrst), .want_sync(want_sync), .sync_n_pin(sync_n_pin));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    function automatic logic [15:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng[15:0];
    endfunction

    // Expected lane shaping: LSB replacement, then reversal, then per-bit byte swap
    function automatic logic [15:0] shape(logic [15:0] s, logic f, logic lf, logic fl, logic re);
        logic [15:0] r;
        logic [15:0] o;
        r = s;
        if (lf) r[0] = f;
        o = r;
        if (fl) for (int i = 0; i < 16; i++) o[i] = r[15-i];
        r = o;
        if (re) for (int i = 0; i < 16; i++) o[i] = map[i%8] ? r[i^8] : r[i];
        return o;
    endfunction

    task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", name, e, g);
            n_errors++;
        end
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask

    task automatic data_chk(input logic lf, input logic fl, input logic re);
        sample_a <= rnd();
        sample_b <= rnd();
        cyc(4);
        chk("data_a", shape(sample_a, fast_overrange_flag_a, lf, fl, re), data_a);
        chk("data_b", shape(sample_b, fast_overrange_flag_b, lf, fl, re), data_b);
    endtask

    // Read data stand only in the cycle after the strobe
    always @(posedge clk) begin
        if (rd_seen) chk("reg_rdata", {8'h00, exp_q.pop_front()}, {8'h00, reg_rdata});
        rd_seen <= reg_rd;
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            finish_test();
        end
    end

    initial begin
        {nrst, reg_wr, reg_rd, fast_overrange_flag_a, fast_overrange_flag_b, want_sync} = 6'h00;
        {reg_addr, reg_wdata, map} = 24'h000000;
        {sample_a, sample_b} = 32'h00000000;
        cyc(2);
        nrst <= 1'b1;
        chk("fpm_reset", 16'h0005, 16'(fpm));
        rd(AOLC_OFS_LINK_CTRL, 8'h00);
        rd(AOLC_OFS_REORD_EN, 8'h00);
        rd(AOLC_OFS_LSB_EN, 8'h00);
        rd(AOLC_OFS_LSB_SEL, 8'h00);
        rd(8'h55, 8'h00);
        wr(AOLC_OFS_LINK_CTRL, 8'h9F);
        rd(AOLC_OFS_LINK_CTRL, 8'h9F);
        for (int b = 0; b < 5; b++) begin
            wr(AOLC_OFS_LINK_CTRL, 8'h01 << b);
            cyc(3);
            chk("link_outs", 16'({b == 4, b == 2, b == 1, b == 0}),
                16'({data_is_pattern, lane_align_en, frame_align_en, ila_skip}));
            if (b == 3) data_chk(1'b0, 1'b1, 1'b0);
        end
        wr(AOLC_OFS_K_COUNT, 8'h0C);
        wr(AOLC_OFS_LINK_CTRL, 8'h80);
        cyc(3);
        chk("fpm_reg", 16'h000C, 16'(fpm));
        wr(AOLC_OFS_LINK_CTRL, 8'h00);
        cyc(3);
        chk("fpm_default", 16'h0005, 16'(fpm));
        fast_overrange_flag_a <= 1'b1;
        for (int e = 0; e < 2; e++) begin
            for (int c = 0; c < 4; c++) begin
                wr(AOLC_OFS_LSB_EN, 8'(e));
                wr(AOLC_OFS_LSB_SEL, 8'(c));
                rd(AOLC_OFS_LSB_SEL, 8'(c));
                data_chk(e == 1 && c == 3, 1'b0, 1'b0);
            end
        end
        wr(AOLC_OFS_LSB_EN, 8'h00);
        map = 8'(rnd());
        wr(AOLC_OFS_REORD_MAP, map);
        wr(8'h52, 8'h80);
        wr(AOLC_OFS_REORD_EN, 8'h08);
        rd(AOLC_OFS_REORD_EN, 8'h00);
        data_chk(1'b0, 1'b0, 1'b1);
        wr(AOLC_OFS_REORD_EN, 8'h00);
        wr(AOLC_OFS_DIG_RST, 8'h01);
        hi = 0;
        repeat (10) @(posedge clk) hi += int'(drst === 1'b1);
        chk("reset_width", 16'h0004, 16'(hi));
        rd(AOLC_OFS_DIG_RST, 8'h00);
        fast_overrange_flag_a <= 1'b0;
        want_sync <= 1'b1;
        cyc(6);
        chk("sync_pin", 16'h0001, 16'(sync_req));
        want_sync <= 1'b0;
        cyc(6);
        chk("sync_idle", 16'h0000, 16'(sync_req));
        wr(AOLC_OFS_SYNC_CTRL, 8'hC0);
        cyc(4);
        chk("sync_reg", 16'h0003, 16'({sync_req, data_is_k}));
        chk("k_fill", {AOLC_K28_5, AOLC_K28_5}, data_a);
        wr(AOLC_OFS_SYNC_CTRL, 8'h40);
        cyc(3);
        chk("sync_off", 16'h0000, 16'({sync_req, data_is_k}));
        wr(AOLC_OFS_IRQ_MASK, 8'h00);
        rd(AOLC_OFS_IRQ_STAT, 8'h07);
        wr(AOLC_OFS_IRQ_STAT, 8'h07);
        rd(AOLC_OFS_IRQ_STAT, 8'h00);
        wr(AOLC_OFS_IRQ_MASK, 8'h02);
        cyc(2);
        chk("irq_idle", 16'h0000, 16'(irq));
        fast_overrange_flag_a <= 1'b1;
        @(posedge clk);
        fast_overrange_flag_a <= 1'b0;
        cyc(3);
        chk("irq_set", 16'h0001, 16'(irq));
        rd(AOLC_OFS_IRQ_STAT, 8'h02);
        wr(AOLC_OFS_IRQ_MASK, 8'h00);
        cyc(3);
        chk("irq_masked", 16'h0000, 16'(irq));
        wr(AOLC_OFS_IRQ_MASK, 8'h02);
        wr(AOLC_OFS_IRQ_STAT, 8'h02);
        cyc(3);
        chk("irq_cleared", 16'h0000, 16'(irq));
        cyc(2);
        finish_test();
    end
endmodule
`default_nettype wire
